// [logic/fcds_sequencer.sv]
`timescale 1ns/100ps
// Behaviour
// R01 - All alternate: channels one to four in order, one per sweep.
// R02 - First pair alternating, second fixed on three: 1,2,3,3.
// R03 - Locked dual time base: 1 on A, 3 on B, 2 on A, 4 on B.
// R04 - Intensified delayed alternate: each channel gets B sweep then A sweep.
// R05 - Display free_run_segment_switch, pairs alternate: free_run_segment_switch 1/3, next sweep 2/4.
// R06 - Display free_run_segment_switch, pair one chopping: second-pair channels get double segments.
// R07 - All free_run_segment_switch: step all four channels on successive free_run_segment_switch intervals.
// R08 - Pair add: one trace, positions of both channels summed.
// R09 - All add: single trace, all four positions summed.
// R10 - Alternate switching only at sweep end, never free-running.
// R11 - Free_run_segment_switch free-running: about 2 us shown, 0.5 us blanked.
// R12 - Lock: channels one, two on sweep A; three, four on B.
// R13 - Host gives one sweep-end pulse per sweep, tagged with time base.
module fcds_sequencer
  import fcds_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sweep-end pins from the mainframe
  input wire logic sweepEndA,
  input wire logic sweepEndB,
  // Display outputs
  output logic [3:0] chanEnable,
  output logic traceBlank,
  output logic sweepSelB,
  output logic signed [9:0] traceLevel
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] posReg;
  logic apbWr;
  logic apbHit;

  assign apbWr = psel & penable & pwrite;
  assign pready = 1'b1;
  assign apbHit = (paddr == FCDS_CTRL_OFS) || (paddr == FCDS_STAT_OFS) ||
                  (paddr == FCDS_POS_OFS) || (paddr == FCDS_SUM_OFS);
  // Unmapped addresses answer with an error, writes dropped
  assign pslverr = psel & penable & ~apbHit;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= FCDS_CTRL_RST;
    end else if (apbWr && paddr == FCDS_CTRL_OFS) begin
      ctrl <= pwdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      posReg <= FCDS_POS_RST;
    end else if (apbWr && paddr == FCDS_POS_OFS) begin
      posReg <= pwdata;
    end
  end

  logic [2:0] firstPairMode;
  logic [2:0] secondPairMode;
  logic [2:0] dispMode;
  logic timebaseLockSelect;
  logic intensifiedDelayedAlternate;
  logic seqEnable;

  assign firstPairMode = ctrl[FCDS_P1_LSB +: 3];
  assign secondPairMode = ctrl[FCDS_P2_LSB +: 3];
  assign dispMode = ctrl[FCDS_DISP_LSB +: 3];
  assign timebaseLockSelect = ctrl[FCDS_LOCK_BIT];
  assign intensifiedDelayedAlternate = ctrl[FCDS_IDA_BIT];
  assign seqEnable = ctrl[FCDS_EN_BIT];

  // ----------------------------------------------------------------
  // Sweep-end inputs
  // ----------------------------------------------------------------
  logic endA;
  logic endB;

  fcds_sync u_syncA (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(sweepEndA),
    .risePulse(endA)
  );

  fcds_sync u_syncB (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(sweepEndB),
    .risePulse(endB)
  );

  // ----------------------------------------------------------------
  // Alternate stepping
  // ----------------------------------------------------------------
  logic sweepEnd;
  logic holdHalf;
  logic altTick;

  // R13 tagged sweep ends
  assign sweepEnd = endA | endB;

  // R04 hold for B then A
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      holdHalf <= 1'b0;
    end else if (!intensifiedDelayedAlternate) begin
      holdHalf <= 1'b0;
    end else if (sweepEnd) begin
      holdHalf <= ~holdHalf;
    end
  end

  // R10 step only at sweep end
  assign altTick = seqEnable & sweepEnd &
                   (~intensifiedDelayedAlternate | holdHalf);

  // Display phase: 0 shows pair one, 1 shows pair two
  logic dispPhase;
  logic pairOneStep;
  logic pairTwoStep;
  logic dispAlt;
  logic dispChop;

  assign dispAlt = dispMode == FCDS_M_ALT;
  assign dispChop = dispMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH;

  // ----------------------------------------------------------------
  // Free_run_segment_switch clock: 2 us shown, 0.5 us blanked
  // ----------------------------------------------------------------
  logic [FCDS_CNT_W-1:0] chopCnt;
  logic chopTick;
  logic blanking;

  // R11 free-running segment timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chopCnt <= '0;
    end else if (chopCnt ==
                 FCDS_CNT_W'(FCDS_SHOW_CYC + FCDS_BLANK_CYC - 1)) begin
      chopCnt <= '0;
    end else begin
      chopCnt <= chopCnt + 1'b1;
    end
  end

  assign blanking = chopCnt >= FCDS_CNT_W'(FCDS_SHOW_CYC);
  assign chopTick = seqEnable &
    (chopCnt == FCDS_CNT_W'(FCDS_SHOW_CYC + FCDS_BLANK_CYC - 1));

  logic altHalf;

  // R01 unlocked: each pair keeps two sweeps
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      altHalf <= 1'b0;
    end else if (!dispAlt || timebaseLockSelect) begin
      altHalf <= 1'b0;
    end else if (altTick) begin
      altHalf <= ~altHalf;
    end
  end

  // Display phase toggles on free_run_segment_switch ticks or alternate steps
  // R03 locked display swaps pairs every sweep
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dispPhase <= 1'b0;
    end else if ((dispAlt && altTick && (timebaseLockSelect || altHalf)) ||
                 (dispChop && chopTick)) begin
      dispPhase <= ~dispPhase;
    end
  end

  // R01 shown pair steps on every sweep end
  // R05 free_run_segment_switch display: pairs step per sweep
  // R06 pair one chops at half rate
  // R07 all-free_run_segment_switch walks 1,3,2,4
  always_comb begin
    pairOneStep = 1'b0;
    pairTwoStep = 1'b0;
    if (dispAlt) begin
      pairOneStep = altTick & ~dispPhase;
      pairTwoStep = altTick & dispPhase;
    end else if (dispChop) begin
      pairOneStep = (firstPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH) ?
                    chopTick & dispPhase : altTick;
      pairTwoStep = (secondPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH) ?
                    chopTick & dispPhase : altTick;
    end else begin
      pairOneStep = (firstPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH) ? chopTick : altTick;
      pairTwoStep = (secondPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH) ? chopTick : altTick;
    end
  end

  logic [1:0] maskOne;
  logic [1:0] maskTwo;

  // R02 fixed second pair repeats its channel
  fcds_pair u_pairOne (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pairMode(firstPairMode),
    .altStep(pairOneStep & (firstPairMode == FCDS_M_ALT)),
    .chopStep(pairOneStep & (firstPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH)),
    .chanMask(maskOne)
  );

  fcds_pair u_pairTwo (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pairMode(secondPairMode),
    .altStep(pairTwoStep & (secondPairMode == FCDS_M_ALT)),
    .chopStep(pairTwoStep & (secondPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH)),
    .chanMask(maskTwo)
  );

  // ----------------------------------------------------------------
  // Display selector
  // ----------------------------------------------------------------
  logic [3:0] next_chanEnable;

  // R09 add shows all four composites
  always_comb begin
    unique case (dispMode)
      FCDS_M_FIRST: next_chanEnable = {2'h0, maskOne};
      FCDS_M_SECOND: next_chanEnable = {maskTwo, 2'h0};
      FCDS_M_ADD: next_chanEnable = {maskTwo, maskOne};
      FCDS_M_ALT, FCDS_M_FREE_RUN_SEGMENT_SWITCH:
        next_chanEnable = dispPhase ? {maskTwo, 2'h0} : {2'h0, maskOne};
      default: next_chanEnable = {2'h0, maskOne};
    endcase
  end

  // Summed positioning level of enabled channels
  logic signed [9:0] next_level;

  // R08 pair add sums both positions
  always_comb begin
    next_level = '0;
    for (int i = 0; i < 4; i++) begin
      if (next_chanEnable[i]) begin
        next_level = next_level +
          10'(signed'(posReg[8*i +: 8]));
      end
    end
  end

  logic chopActive;

  assign chopActive = dispChop || (!dispAlt &&
    ((dispMode != FCDS_M_SECOND && firstPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH) ||
     (dispMode != FCDS_M_FIRST && secondPairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH)));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chanEnable <= 4'h0;
      traceBlank <= 1'b1;
      traceLevel <= '0;
    end else begin
      chanEnable <= seqEnable ? next_chanEnable : 4'h0;
      traceBlank <= ~seqEnable | (chopActive & blanking);
      // No lit channel, so no level either
      traceLevel <= seqEnable ? next_level : 10'sh000;
    end
  end

  // R12 lock pairs to sweeps
  // R03 locked order 1A,3B,2A,4B
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sweepSelB <= 1'b0;
    end else if (timebaseLockSelect && dispAlt) begin
      sweepSelB <= dispPhase;
    end else begin
      sweepSelB <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      FCDS_CTRL_OFS: prdata = ctrl;
      FCDS_STAT_OFS: prdata = {25'h0, sweepSelB, dispPhase, traceBlank,
                               chanEnable};
      FCDS_POS_OFS: prdata = posReg;
      FCDS_SUM_OFS: prdata = {{22{traceLevel[9]}}, traceLevel};
      default: prdata = 32'h0000_0000;
    endcase
  end

endmodule

// [shared/fcds_pkg.sv]
package fcds_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] FCDS_CTRL_OFS = 12'h000;
  localparam logic [11:0] FCDS_STAT_OFS = 12'h004;
  localparam logic [11:0] FCDS_POS_OFS = 12'h008;
  localparam logic [11:0] FCDS_SUM_OFS = 12'h00C;

  // CTRL fields
  localparam int FCDS_P1_LSB = 0;
  localparam int FCDS_P2_LSB = 3;
  localparam int FCDS_DISP_LSB = 6;
  localparam int FCDS_LOCK_BIT = 9;
  localparam int FCDS_IDA_BIT = 10;
  localparam int FCDS_EN_BIT = 11;
  localparam logic [31:0] FCDS_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] FCDS_POS_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] FCDS_M_FIRST = 3'h0;
  localparam logic [2:0] FCDS_M_ALT = 3'h1;
  localparam logic [2:0] FCDS_M_FREE_RUN_SEGMENT_SWITCH = 3'h2;
  localparam logic [2:0] FCDS_M_ADD = 3'h3;
  localparam logic [2:0] FCDS_M_SECOND = 3'h4;

  // ----------------------------------------------------------------
  // Free_run_segment_switch timing
  // ----------------------------------------------------------------
  localparam int FCDS_CLK_MHZ = 125;
  localparam int FCDS_SHOW_NS = 2000;
  localparam int FCDS_BLANK_NS = 500;
  localparam int FCDS_SHOW_CYC = FCDS_SHOW_NS * FCDS_CLK_MHZ / 1000;
  localparam int FCDS_BLANK_CYC = FCDS_BLANK_NS * FCDS_CLK_MHZ / 1000;
  localparam int FCDS_CNT_W = 9;

endpackage

// [logic/fcds_sync.sv]
`timescale 1ns/100ps
module fcds_sync
  import fcds_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin level in, clean pulse out
  input wire logic pinIn,
  output logic risePulse
);

  logic stageA;
  logic stageB;
  logic stageC;

  // Two flops before any logic, third for edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stageA <= 1'b0;
      stageB <= 1'b0;
      stageC <= 1'b0;
    end else begin
      stageA <= pinIn;
      stageB <= stageA;
      stageC <= stageB;
    end
  end

  assign risePulse = stageB & ~stageC;

endmodule

// [logic/fcds_pair.sv]
`timescale 1ns/100ps
module fcds_pair
  import fcds_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic [2:0] pairMode,
  input wire logic altStep,
  input wire logic chopStep,
  // Composite selection
  output logic [1:0] chanMask
);

  logic which;

  // Toggle on alternate or free_run_segment_switch step per mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      which <= 1'b0;
    end else if ((pairMode == FCDS_M_ALT && altStep) ||
                 (pairMode == FCDS_M_FREE_RUN_SEGMENT_SWITCH && chopStep)) begin
      which <= ~which;
    end
  end

  always_comb begin
    unique case (pairMode)
      FCDS_M_FIRST: chanMask = 2'h1;
      FCDS_M_SECOND: chanMask = 2'h2;
      FCDS_M_ADD: chanMask = 2'h3;
      FCDS_M_ALT, FCDS_M_FREE_RUN_SEGMENT_SWITCH: chanMask = which ? 2'h2 : 2'h1;
      default: chanMask = 2'h1;
    endcase
  end

endmodule

// [tb/fcds_host_model.sv]
`timescale 1ns/100ps
module fcds_host_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Sweep request
  input wire logic sweepReq,
  input wire logic useB,
  // Sweep-end pins
  output logic sweepEndA,
  output logic sweepEndB
);
  logic [3:0] cnt;
  logic selB;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      selB <= 1'b0;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (sweepReq) begin
      cnt <= 4'h8;
      selB <= useB;
    end
  end
  assign sweepEndA = cnt > 4'h4 && !selB;
  assign sweepEndB = cnt > 4'h4 && selB;
endmodule

// [tb/fcds_sequencer_checker.sv]
`timescale 1ns/100ps
module fcds_sequencer_checker
  import fcds_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sweep pins and display
  input wire logic sweepEndA,
  input wire logic sweepEndB,
  input wire logic [3:0] chanEnable,
  input wire logic traceBlank,
  input wire logic sweepSelB,
  input wire logic signed [9:0] traceLevel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic acc, bad, sw;
  assign acc = psel && penable;
  assign bad = paddr > 12'h00C || paddr[1:0] != 2'h0;
  assign sw = sweepEndA || sweepEndB;
  property p_ready;
    acc |-> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err;
    acc && bad |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped ok");
  property p_ok;
    acc && !bad |-> !pslverr;
  endproperty
  a_ok: assert property (p_ok) else $error("mapped err");
  property p_blank;
    $rose(traceBlank) && !$past(psel) && !$past(psel, 2)
      |=> traceBlank [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("short blank");
  property p_show;
    $fell(traceBlank) |=> !traceBlank [*8];
  endproperty
  a_show: assert property (p_show) else $error("short show");
  // Only sweep ends or writes may move a lit trace
  property p_step;
    $changed(chanEnable) && !traceBlank && !$past(traceBlank) &&
      !$past(psel) && !$past(psel, 2) && !$past(psel, 3)
      |-> $past(sw, 3) || $past(sw, 4);
  endproperty
  a_step: assert property (p_step) else $error("free step");
  property p_selb;
    sweepSelB |-> chanEnable[1:0] == 2'h0;
  endproperty
  a_selb: assert property (p_selb) else $error("pair on B");
  property p_dark;
    chanEnable == 4'h0 |-> traceBlank && traceLevel == 10'sh000;
  endproperty
  a_dark: assert property (p_dark) else $error("dark level");
  c_seg: cover property ($fell(traceBlank));
  c_selb: cover property ($rose(sweepSelB));
  c_bad: cover property (acc && bad);
endmodule
bind fcds_sequencer fcds_sequencer_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sweepEndA(sweepEndA), .sweepEndB(sweepEndB),
  .chanEnable(chanEnable), .traceBlank(traceBlank),
  .sweepSelB(sweepSelB), .traceLevel(traceLevel)
);

// [tb/test_fcds_sequencer.sv]
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    nCompared++; \
    if ((g) !== (e)) begin \
      nFail++; \
      $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e); \
    end \
  end
module test_fcds_sequencer
  import fcds_pkg::*;
;
  localparam logic [31:0] ADD_C [3] = '{32'h803, 32'h918, 32'h8DB};
  localparam logic [31:0] ADD_S [3] = '{32'hFFFFFFFE, 32'hC, 32'hA};
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic sweepEndA, sweepEndB, traceBlank, sweepSelB, sweepReq, useB, err;
  logic [3:0] chanEnable;
  logic signed [9:0] traceLevel;
  logic [15:0] p1, p2;
  int n, i, nFail, nCompared, cyc;
  fcds_sequencer DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sweepEndA(sweepEndA),
    .sweepEndB(sweepEndB), .chanEnable(chanEnable),
    .traceBlank(traceBlank), .sweepSelB(sweepSelB),
    .traceLevel(traceLevel)
  );
  fcds_host_model u_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .sweepReq(sweepReq), .useB(useB),
    .sweepEndA(sweepEndA), .sweepEndB(sweepEndB)
  );
  task automatic endSim();
    $display("Compared %0d, failed %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic sweep(input logic b);
    useB <= b;
    sweepReq <= 1'b1;
    @(posedge ref_clk);
    sweepReq <= 1'b0;
    repeat (11) @(posedge ref_clk);
  endtask
  task automatic waitLvl(input logic v, output int m);
    m = 0;
    while (traceBlank === v) begin
      @(posedge ref_clk);
      m++;
    end
  endtask
  // Per-channel segment counts, one nibble each
  task automatic seg8(output logic [15:0] pk);
    int m, j;
    pk = 16'h0;
    for (j = 0; j < 8; j++) begin
      waitLvl(1'b0, m);
      waitLvl(1'b1, m);
      pk = pk + {3'h0, chanEnable[3], 3'h0, chanEnable[2],
                 3'h0, chanEnable[1], 3'h0, chanEnable[0]};
    end
  endtask
  // Start phase is free, so any rotation of the cycle matches
  task automatic altSeq(input logic [31:0] c, input logic [31:0] ex,
                        input logic [1:0] k);
    logic [31:0] got;
    logic [63:0] dd;
    logic hit;
    int j;
    apb(1'b1, FCDS_CTRL_OFS, c, r);
    repeat (4) @(posedge ref_clk);
    for (j = 0; j < 8; j++) begin
      got = {got[27:0], chanEnable};
      if (k == 2'h1) `CHK(sweepSelB, |chanEnable[3:2])
      sweep(k == 2'h1 ? sweepSelB : (k == 2'h2 && !j[0]));
    end
    hit = 1'b0;
    for (j = 0; j < 8; j++) begin
      dd = {ex, ex} >> (4 * j);
      hit = hit | (dd[31:0] === got);
    end
    `CHK(hit, 1'b1)
    got[3:0] = chanEnable;
    repeat (400) @(posedge ref_clk);
    `CHK(chanEnable, got[3:0])
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      nFail++;
      endSim();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, sweepReq, useB} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, FCDS_CTRL_OFS, 32'h0, r);
    `CHK(r, FCDS_CTRL_RST)
    apb(1'b0, FCDS_POS_OFS, 32'h0, r);
    `CHK(r, FCDS_POS_RST)
    apb(1'b0, FCDS_STAT_OFS, 32'h0, r);
    `CHK(r[4:0], 5'h10)
    apb(1'b1, FCDS_SUM_OFS, 32'h155, r);
    apb(1'b0, FCDS_SUM_OFS, 32'h0, r);
    `CHK(r, 32'h0)
    apb(1'b1, 12'h010, 32'hFFFFFFFF, r);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h010, 32'h0, r);
    `CHK({err, r}, {1'b1, 32'h0})
    apb(1'b1, FCDS_POS_OFS, 32'h0804FD01, r);
    apb(1'b0, FCDS_POS_OFS, 32'h0, r);
    `CHK(r, 32'h0804FD01)
    altSeq(32'h849, 32'h12481248, 2'h0);
    altSeq(32'h841, 32'h12441244, 2'h0);
    altSeq(32'hA49, 32'h14281428, 2'h1);
    altSeq(32'hC49, 32'h11224488, 2'h2);
    apb(1'b1, FCDS_CTRL_OFS, 32'h889, r);
    seg8(p1);
    `CHK(p1 == 16'h0404 || p1 == 16'h4040, 1'b1)
    sweep(1'b0);
    seg8(p2);
    `CHK(p2, p1 ^ 16'h4444)
    apb(1'b1, FCDS_CTRL_OFS, 32'h88A, r);
    seg8(p1);
    `CHK(p1 == 16'h0422 || p1 == 16'h4022, 1'b1)
    apb(1'b1, FCDS_CTRL_OFS, 32'h892, r);
    seg8(p1);
    `CHK(p1, 16'h2222)
    waitLvl(1'b0, n);
    `CHK(n, FCDS_SHOW_CYC)
    waitLvl(1'b1, n);
    `CHK(n, FCDS_BLANK_CYC)
    for (i = 0; i < 3; i++) begin
      apb(1'b1, FCDS_CTRL_OFS, ADD_C[i], r);
      repeat (4) @(posedge ref_clk);
      `CHK(traceLevel, ADD_S[i][9:0])
      apb(1'b0, FCDS_SUM_OFS, 32'h0, r);
      `CHK(r, ADD_S[i])
    end
    endSim();
  end
endmodule
